// ---- pkg/omc_defs.vh ----
// constants for the optical module management controller
`ifndef OMC_DEFS_VH
`define OMC_DEFS_VH
`define OMC_DEV_ADDR 7'h50
`define OMC_TBL_SEL_ADDR 8'h7f
`define OMC_LOWER_SIZE 128
`define OMC_NUM_TABLES 4
`define OMC_TBL_BITS 2
`define OMC_BYTE_LOCK_ADDR 8'h00
`define OMC_BYTE_STATUS_ADDR 8'h01
`define OMC_BYTE_MASK_ADDR 8'h02
`define OMC_BYTE_CTRL_ADDR 8'h03
`define OMC_BIT_LOS 0
`define OMC_BIT_FAULT 1
`define OMC_BIT_LASER_OFF 2
`define OMC_BIT_PWR_DOWN 3
`define OMC_MASK_RESET 8'h0f
`define OMC_CTRL_RESET 8'h00
`define OMC_CTRL_SOFT_LASER_OFF 0
`define OMC_AXI_OFF_STATUS 32'h0000_0000
`define OMC_AXI_OFF_MASK 32'h0000_0004
`define OMC_AXI_OFF_CTRL 32'h0000_0008
`define OMC_AXI_OFF_LEVEL 32'h0000_000c
`define OMC_AXI_OFF_TABLE 32'h0000_0010
`define OMC_AXI_RESP_OK 2'b00
`define OMC_AXI_RESP_SLVERR 2'b10
`endif

// ---- verilog/omc_top.v ----
// optical module management: 2-wire slave, paged byte map, pins, axi4-lite registers
`timescale 1ns/100ps
`include "omc_defs.vh"

// How it works
// - ignore bus unless select pin is low
// - alert output low on unmasked status bit
// - laser off while disable input high
// - loss output high while signal lost
// - not-ready output asserted on internal fault
// - absent output always driven low
// - power-down input high enters low power
// - serial interface keeps working in low power
// - power-down falling edge resets the controller registers; byte map contents are kept
// - answer at seven-bit device address 1010000
// - serial map gives id, diagnostics, control
// - 256 bytes, two halves of 128
// - lower half directly accessible, no paging
// - upper half paged by table-select byte
module omc_top #(
   parameter [6:0] DEV_ADDR = `OMC_DEV_ADDR,
   parameter [7:0] TBL_SEL_ADDR = `OMC_TBL_SEL_ADDR
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // module pins
   input wire unit_select_low,
   input wire laser_off_in,
   input wire pwr_down_rst,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   output reg alert_n,
   output reg rx_signal_lost,
   output reg unit_not_ready,
   output reg unit_absent,
   // internal sources
   input wire optical_loss,
   input wire fault,
   output reg laser_enable,
   output reg low_power,
   output reg irq
);
   localparam S_IDLE = 6'b000001;
   localparam S_ADDR = 6'b000010;
   localparam S_AACK = 6'b000100;
   localparam S_RX = 6'b001000;
   localparam S_TX = 6'b010000;
   localparam S_TACK = 6'b100000;

   reg [7:0] mem_q [0:255 + 128 * (`OMC_NUM_TABLES - 1)];
   reg [1:0] sel_s_q, lz_s_q, pd_s_q, scl_s_q, sda_s_q, los_s_q, flt_s_q;
   reg scl_prev_q, sda_prev_q, pd_prev_q;
   reg [5:0] st_q;
   reg [7:0] shift_q, ptr_q, tbl_q, status_q, mask_q, ctrl_q;
   reg [3:0] bit_q;
   reg rw_q, ptr_ok_q, nack_q;
   reg [31:0] rd_d;
   reg aw_q, w_q;
   reg [31:0] awaddr_q, wdata_q;
   wire soft_rst, scl_rise, scl_fall, start_c, stop_c, sel, lv_los, lv_flt, lv_lz, stat_rd;
   wire [7:0] live, rd_byte;
   wire [31:0] aw_word, ar_word;

   // the last page ends at 639, so the index needs ten bits
   function [9:0] map_idx;
      input [7:0] a;
      input [7:0] t;
      begin
         // lower half unpaged, upper half paged
         if (a[7])
            map_idx = {2'b00, a} + {1'b0, t[`OMC_TBL_BITS-1:0], 7'h00};
         else
            map_idx = {2'b00, a};
      end
   endfunction

   always @(posedge aclk) begin
      sel_s_q <= {sel_s_q[0], unit_select_low};
      lz_s_q <= {lz_s_q[0], laser_off_in};
      pd_s_q <= {pd_s_q[0], pwr_down_rst};
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      los_s_q <= {los_s_q[0], optical_loss};
      flt_s_q <= {flt_s_q[0], fault};
      scl_prev_q <= scl_s_q[1];
      sda_prev_q <= sda_s_q[1];
      pd_prev_q <= pd_s_q[1];
   end

   assign soft_rst = !aresetn || (pd_prev_q && !pd_s_q[1]);
   assign scl_rise = scl_s_q[1] && !scl_prev_q;
   assign scl_fall = !scl_s_q[1] && scl_prev_q;
   assign start_c = scl_s_q[1] && sda_prev_q && !sda_s_q[1];
   assign stop_c = scl_s_q[1] && !sda_prev_q && sda_s_q[1];
   assign sel = !sel_s_q[1];
   assign lv_los = los_s_q[1];
   assign lv_flt = flt_s_q[1];
   assign lv_lz = lz_s_q[1];
   assign live = {4'h0, pd_s_q[1], lv_lz, lv_flt, lv_los};
   assign aw_word = {awaddr_q[31:2], 2'b00};
   assign ar_word = {s_axi_araddr[31:2], 2'b00};
   // status clears only on an accepted read of its own word
   assign stat_rd = s_axi_arvalid && s_axi_arready && ar_word == `OMC_AXI_OFF_STATUS;
   assign rd_byte = (ptr_q == `OMC_BYTE_STATUS_ADDR) ? status_q :
                    (ptr_q == `OMC_BYTE_MASK_ADDR) ? mask_q :
                    (ptr_q == `OMC_BYTE_CTRL_ADDR) ? ctrl_q :
                    (ptr_q == `OMC_BYTE_LOCK_ADDR) ? live :
                    (ptr_q == TBL_SEL_ADDR) ? tbl_q : mem_q[map_idx(ptr_q, tbl_q)];

   always @(posedge aclk) begin
      if (soft_rst) begin
         st_q <= S_IDLE;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         tbl_q <= 8'h00;
         bit_q <= 4'h0;
         rw_q <= 1'b0;
         ptr_ok_q <= 1'b0;
         nack_q <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         status_q <= 8'h00;
         mask_q <= `OMC_MASK_RESET;
         ctrl_q <= `OMC_CTRL_RESET;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OMC_AXI_RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `OMC_AXI_RESP_OK;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
      end else begin
         if (!sel || stop_c) begin
            st_q <= S_IDLE;
            sda_oe <= 1'b0;
         end else if (start_c) begin
            st_q <= S_ADDR;
            bit_q <= 4'h0;
            sda_oe <= 1'b0;
         end else begin
            case (st_q)
               S_IDLE: begin
                  sda_oe <= 1'b0;
               end
               S_ADDR, S_RX: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s_q[1]};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     if (st_q == S_ADDR) begin
                        if (shift_q[7:1] == DEV_ADDR) begin
                           rw_q <= shift_q[0];
                           ptr_ok_q <= 1'b0;
                           sda_oe <= 1'b1;
                           st_q <= S_AACK;
                        end else begin
                           st_q <= S_IDLE;
                        end
                     end else begin
                        sda_oe <= 1'b1;
                        st_q <= S_AACK;
                        if (!ptr_ok_q) begin
                           ptr_q <= shift_q;
                           ptr_ok_q <= 1'b1;
                        end else begin
                           if (ptr_q == TBL_SEL_ADDR)
                              tbl_q <= shift_q;
                           else if (ptr_q == `OMC_BYTE_MASK_ADDR)
                              mask_q <= shift_q;
                           else if (ptr_q == `OMC_BYTE_CTRL_ADDR)
                              ctrl_q <= shift_q;
                           else if (ptr_q == `OMC_BYTE_STATUS_ADDR)
                              status_q <= status_q;
                           else
                              mem_q[map_idx(ptr_q, tbl_q)] <= shift_q;
                           ptr_q <= ptr_q + 8'h01;
                        end
                     end
                  end
               end
               S_AACK: begin
                  sda_out <= 1'b0;
                  if (scl_fall) begin
                     if (rw_q) begin
                        shift_q <= rd_byte;
                        sda_oe <= !rd_byte[7];
                        bit_q <= 4'h1;
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= S_TX;
                     end else begin
                        sda_oe <= 1'b0;
                        st_q <= S_RX;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (bit_q == 4'h8) begin
                        sda_oe <= 1'b0;
                        st_q <= S_TACK;
                     end else begin
                        sda_out <= 1'b0;
                        sda_oe <= !shift_q[3'd7 - bit_q[2:0]];
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               S_TACK: begin
                  if (scl_rise)
                     nack_q <= sda_s_q[1];
                  else if (scl_fall) begin
                     if (nack_q)
                        st_q <= S_IDLE;
                     else begin
                        shift_q <= rd_byte;
                        sda_out <= 1'b0;
                        sda_oe <= !rd_byte[7];
                        bit_q <= 4'h1;
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= S_TX;
                     end
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end

         // status events: set wins over read clear
         status_q[`OMC_BIT_LOS] <= lv_los ||
            (status_q[`OMC_BIT_LOS] && !stat_rd);
         status_q[`OMC_BIT_FAULT] <= lv_flt ||
            (status_q[`OMC_BIT_FAULT] && !stat_rd);
         status_q[`OMC_BIT_LASER_OFF] <= lv_lz ||
            (status_q[`OMC_BIT_LASER_OFF] && !stat_rd);
         status_q[`OMC_BIT_PWR_DOWN] <= pd_s_q[1] ||
            (status_q[`OMC_BIT_PWR_DOWN] && !stat_rd);

         // axi write: address and data in either order
         s_axi_awready <= !aw_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         if (aw_q && w_q && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `OMC_AXI_RESP_OK;
            if (aw_word == `OMC_AXI_OFF_MASK)
               mask_q <= wdata_q[7:0];
            else if (aw_word == `OMC_AXI_OFF_CTRL)
               ctrl_q <= wdata_q[7:0];
            else if (aw_word == `OMC_AXI_OFF_TABLE)
               tbl_q <= wdata_q[7:0];
            else if (aw_word != `OMC_AXI_OFF_STATUS &&
                     aw_word != `OMC_AXI_OFF_LEVEL)
               s_axi_bresp <= `OMC_AXI_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
         end

         // axi read
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= (rd_d == 32'hffff_ffff) ? `OMC_AXI_RESP_SLVERR : `OMC_AXI_RESP_OK;
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   always @* begin
      case (ar_word)
         `OMC_AXI_OFF_STATUS: rd_d = {24'h00_0000, status_q};
         `OMC_AXI_OFF_MASK: rd_d = {24'h00_0000, mask_q};
         `OMC_AXI_OFF_CTRL: rd_d = {24'h00_0000, ctrl_q};
         `OMC_AXI_OFF_LEVEL: rd_d = {24'h00_0000, live};
         `OMC_AXI_OFF_TABLE: rd_d = {24'h00_0000, tbl_q};
         default: rd_d = 32'hffff_ffff;
      endcase
   end

   // pin outputs, all registered
   always @(posedge aclk) begin
      if (soft_rst) begin
         alert_n <= 1'b1;
         irq <= 1'b0;
         rx_signal_lost <= 1'b0;
         unit_not_ready <= 1'b0;
         unit_absent <= 1'b0;
         laser_enable <= 1'b0;
         low_power <= 1'b0;
      end else begin
         alert_n <= !(|(status_q & mask_q));
         irq <= |(status_q & mask_q);
         rx_signal_lost <= lv_los;
         unit_not_ready <= lv_flt;
         unit_absent <= 1'b0;
         laser_enable <= !lv_lz && !ctrl_q[`OMC_CTRL_SOFT_LASER_OFF] && !pd_s_q[1];
         // low power mode; serial logic keeps running
         low_power <= pd_s_q[1];
      end
   end
endmodule

// ---- sim/omc_props.sv ----
// assertions on the management controller pins
`timescale 1ns/100ps
module omc_props (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // pins and sources
   input wire unit_select_low,
   input wire laser_off_in,
   input wire pwr_down_rst,
   input wire optical_loss,
   input wire fault,
   input wire sda_out,
   input wire sda_oe,
   input wire alert_n,
   input wire irq,
   input wire laser_enable,
   input wire low_power,
   input wire rx_signal_lost,
   input wire unit_not_ready,
   input wire unit_absent
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // five cycles covers the two-stage synchroniser plus the output register
   sequence s_lost; optical_loss [*5]; endsequence
   sequence s_found; !optical_loss [*5]; endsequence
   property p_alert; alert_n == !irq; endproperty
   property p_laser; laser_off_in [*5] |-> !laser_enable; endproperty
   property p_lost; s_lost |-> rx_signal_lost; endproperty
   property p_found; s_found |-> !rx_signal_lost; endproperty
   property p_fault; fault [*5] |-> unit_not_ready; endproperty
   property p_absent; !unit_absent && !sda_out; endproperty
   property p_power; pwr_down_rst [*5] |-> low_power; endproperty
   property p_desel; unit_select_low [*5] |-> !sda_oe; endproperty
   a_alert: assert property (p_alert) else $error("alert and irq disagree");
   a_laser: assert property (p_laser) else $error("laser on while disabled");
   a_lost: assert property (p_lost) else $error("loss not shown");
   a_found: assert property (p_found) else $error("loss shown without cause");
   a_fault: assert property (p_fault) else $error("fault not shown");
   a_absent: assert property (p_absent) else $error("absent or data pin driven high");
   a_power: assert property (p_power) else $error("low power not entered");
   a_desel: assert property (p_desel) else $error("data line driven while deselected");
endmodule

bind omc_top omc_props u_omc_props (
   .aclk(aclk),
   .aresetn(aresetn),
   .unit_select_low(unit_select_low),
   .laser_off_in(laser_off_in),
   .pwr_down_rst(pwr_down_rst),
   .optical_loss(optical_loss),
   .fault(fault),
   .sda_out(sda_out),
   .sda_oe(sda_oe),
   .alert_n(alert_n),
   .irq(irq),
   .laser_enable(laser_enable),
   .low_power(low_power),
   .rx_signal_lost(rx_signal_lost),
   .unit_not_ready(unit_not_ready),
   .unit_absent(unit_absent)
);

// ---- sim/omc_host_model.sv ----
// 2-wire bus host model with an open-drain data line
`timescale 1ns/100ps
`include "omc_defs.vh"
module omc_host_model (
   // bus
   input wire sda_oe,
   output reg scl,
   output wire sda
);
   reg drv_low = 1'b0;
   reg ack = 1'b1;
   // pull-up: a released line reads high
   assign sda = !(drv_low | sda_oe);
   // clock stands high between frames
   initial scl = 1'b1;
   task bit_out(input b);
      drv_low = !b;
      #200 scl = 1'b1;
      #400 scl = 1'b0;
      #200;
   endtask
   task bit_in(output b);
      drv_low = 1'b0;
      #200 scl = 1'b1;
      #200 b = sda;
      #200 scl = 1'b0;
      #200;
   endtask
   task start;
      // odd offset keeps the frame out of phase with the block clock
      #37 drv_low = 1'b0;
      #200 scl = 1'b1;
      #200 drv_low = 1'b1;
      #200 scl = 1'b0;
      #200;
   endtask
   task stop;
      drv_low = 1'b1;
      #200 scl = 1'b1;
      #200 drv_low = 1'b0;
      #200;
   endtask
   task wbyte(input [7:0] v);
      integer i;
      reg b;
      for (i = 7; i >= 0; i--) bit_out(v[i]);
      bit_in(b);
      ack = ack & !b;
   endtask
   task wr(input [6:0] a, input [7:0] p, input [15:0] v, input integer n, output ok);
      integer i;
      ack = 1'b1;
      start;
      wbyte({a, 1'b0});
      wbyte(p);
      for (i = n - 1; i >= 0; i--) wbyte(v[8*i+:8]);
      stop;
      ok = ack;
   endtask
   task rd(input [7:0] p, input integer n, output [15:0] v);
      integer i;
      v = 16'h0000;
      start;
      wbyte({`OMC_DEV_ADDR, 1'b0});
      wbyte(p);
      start;
      wbyte({`OMC_DEV_ADDR, 1'b1});
      for (i = n - 1; i >= 0; i--) begin
         bit_in(v[8*i+7]);
         bit_in(v[8*i+6]);
         bit_in(v[8*i+5]);
         bit_in(v[8*i+4]);
         bit_in(v[8*i+3]);
         bit_in(v[8*i+2]);
         bit_in(v[8*i+1]);
         bit_in(v[8*i]);
         bit_out(i == 0);
      end
      stop;
   endtask
endmodule

// ---- sim/tb_top.sv ----
// testbench for the optical module management controller
`timescale 1ns/100ps
`include "omc_defs.vh"
module tb_top;
   logic aclk = 0;
   logic aresetn = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic unit_select_low = 1, laser_off_in = 0, pwr_down_rst = 0;
   logic optical_loss = 0, fault = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire sda_out, sda_oe, alert_n, rx_signal_lost, unit_not_ready, unit_absent;
   wire laser_enable, low_power, irq, scl, sda;
   integer errors = 0, total_checks = 0;
   logic [31:0] d;
   logic [1:0] r;
   logic [15:0] b;
   logic [7:0] i;
   logic ok;
   always #50 aclk = ~aclk;
   omc_top u_omc_top (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .unit_select_low(unit_select_low),
      .laser_off_in(laser_off_in),
      .pwr_down_rst(pwr_down_rst),
      .scl_in(scl),
      .sda_in(sda),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .alert_n(alert_n),
      .rx_signal_lost(rx_signal_lost),
      .unit_not_ready(unit_not_ready),
      .unit_absent(unit_absent),
      .optical_loss(optical_loss),
      .fault(fault),
      .laser_enable(laser_enable),
      .low_power(low_power),
      .irq(irq)
   );
   omc_host_model u_omc_host_model (.sda_oe(sda_oe), .scl(scl), .sda(sda));
   task end_sim;
      $display("errors=%0d checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input [31:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge aclk);
   endtask
   task axi_wr(input [31:0] a, v);
      integer n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end
      r = s_axi_bresp;
      s_axi_bready <= 0;
      if (n == 50) begin
         chk(0, 1, "write timeout");
         end_sim;
      end
   endtask
   task axi_rd(input [31:0] a);
      integer n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      if (n == 50) begin
         chk(0, 1, "read timeout");
         end_sim;
      end
   endtask
   task t_regs;
      axi_rd(`OMC_AXI_OFF_MASK);
      chk(d, 32'h0000_000f, "mask reset");
      chk(r, `OMC_AXI_RESP_OK, "read okay");
      axi_wr(`OMC_AXI_OFF_CTRL, 32'h0000_0001);
      chk(r, `OMC_AXI_RESP_OK, "write okay");
      tick(2);
      chk(laser_enable, 0, "soft laser off");
      axi_wr(`OMC_AXI_OFF_CTRL, 32'h0000_0000);
      axi_rd(32'h0000_0020);
      chk({r, d[15:0]}, 18'h2_ffff, "unmapped read");
      axi_wr(32'h0000_0020, 32'h0000_0000);
      chk(r, `OMC_AXI_RESP_SLVERR, "unmapped write");
   endtask
   task t_irq;
      axi_rd(`OMC_AXI_OFF_STATUS);
      chk(irq, 0, "irq idle");
      axi_wr(`OMC_AXI_OFF_MASK, 32'h0000_0000);
      optical_loss <= 1;
      tick(8);
      optical_loss <= 0;
      tick(8);
      chk(irq, 0, "masked event");
      axi_wr(`OMC_AXI_OFF_MASK, 32'h0000_000f);
      tick(2);
      chk({irq, alert_n}, 2'b10, "unmasked event");
      axi_rd(`OMC_AXI_OFF_STATUS);
      chk(d, 32'h0000_0001, "status loss");
      tick(2);
      chk(irq, 0, "read clears");
   endtask
   task t_pins;
      laser_off_in <= 1;
      optical_loss <= 1;
      fault <= 1;
      tick(6);
      chk({laser_enable, rx_signal_lost, unit_not_ready, unit_absent}, 4'h6, "set");
      axi_rd(`OMC_AXI_OFF_LEVEL);
      chk(d, 32'h0000_0007, "live levels");
      laser_off_in <= 0;
      optical_loss <= 0;
      fault <= 0;
      tick(6);
      chk({laser_enable, rx_signal_lost, unit_not_ready, unit_absent}, 4'h8, "clear");
   endtask
   task t_wire;
      unit_select_low <= 0;
      tick(4);
      u_omc_host_model.rd(`OMC_BYTE_STATUS_ADDR, 1, b);
      chk(b, 16'h0007, "alert cause");
      chk(alert_n, 0, "alert low");
      u_omc_host_model.wr(`OMC_DEV_ADDR, 8'h10, 16'ha55a, 2, ok);
      chk(ok, 1, "write acked");
      u_omc_host_model.rd(8'h10, 2, b);
      chk(b, 16'ha55a, "auto increment");
      // host side of the paging: select tables 1 and 2, write the first byte of each, then reselect table 1
      for (i = 1; i <= 3; i++) begin
         u_omc_host_model.wr(`OMC_DEV_ADDR, `OMC_TBL_SEL_ADDR, {8'h00, i[0] ? 8'h01 : 8'h02}, 1, ok);
         if (i < 3) u_omc_host_model.wr(`OMC_DEV_ADDR, 8'h80, {8'h00, 8'h30 + i}, 1, ok);
      end
      u_omc_host_model.rd(8'h80, 1, b);
      chk(b, 16'h0031, "paged byte");
      axi_rd(`OMC_AXI_OFF_TABLE);
      chk(d, 32'h0000_0001, "table select");
      u_omc_host_model.rd(8'h10, 1, b);
      chk(b, 16'h00a5, "lower unpaged");
      u_omc_host_model.wr(7'h51, 8'h00, 16'h0000, 0, ok);
      chk(ok, 0, "other address");
      unit_select_low <= 1;
      tick(4);
      u_omc_host_model.wr(`OMC_DEV_ADDR, 8'h00, 16'h0000, 0, ok);
      chk(ok, 0, "deselected");
   endtask
   task t_power;
      unit_select_low <= 0;
      pwr_down_rst <= 1;
      tick(6);
      chk(low_power, 1, "low power");
      u_omc_host_model.rd(8'h10, 1, b);
      chk(b, 16'h00a5, "bus in low power");
      axi_wr(`OMC_AXI_OFF_MASK, 32'h0000_0003);
      pwr_down_rst <= 0;
      tick(8);
      axi_rd(`OMC_AXI_OFF_MASK);
      chk({low_power, d}, 33'h0_0000_000f, "reset on fall");
   endtask
   initial begin
      tick(20);
      aresetn <= 1;
      tick(2);
      t_regs;
      t_irq;
      t_pins;
      t_wire;
      t_power;
      end_sim;
   end
endmodule
